// >>> lpar_readout.sv
// Readout sequencer of a 128-pixel linear light-sensor array.
// Assumes sensor_clk and scan_start are asynchronous pins, sampled on mclk,
// and a front end that streams frozen pixel samples in array order.
//
// Function
// - 128-bit token register stepped by sensor clock
// - Start high on clock edge starts readout
// - Start rising edge raises hold strobe
// - Edge counter presents one stored pixel per clock
// - Integrators reset 18 clocks, release on 19th
// - 129th edge drops token, output floats
// - Output floats whenever not reading out
`timescale 1ns/1ps
module lpar_readout
    import lpar_pkg::*;
#(
    parameter int PIX_BITS = PIX_W,
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sensor_clk,
    input wire logic scan_start,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic [PIX_BITS-1:0] sample_data,
    output logic hold_strobe,
    output logic integ_reset,
    output logic [PIX_BITS-1:0] pixel_analog_out,
    output logic pixel_out_oe_n,
    output logic [IDX_W-1:0] pixel_index,
    output logic readout_busy,
    output logic start_ok,
    output logic start_err
);

    // ************************************************************
    // Pin synchronisers and edge detection
    // ************************************************************
    logic sclk_s1_q;
    logic sclk_s2_q;
    logic sclk_s3_q;
    logic start_s1_q;
    logic start_s2_q;
    logic start_s3_q;
    logic sclk_edge;
    logic start_rise;

    // Two flops per pin; the third only feeds the edge detectors
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            start_s1_q <= 1'b0;
            start_s2_q <= 1'b0;
            start_s3_q <= 1'b0;
        end else begin
            sclk_s1_q <= sensor_clk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            start_s1_q <= scan_start;
            start_s2_q <= start_s1_q;
            start_s3_q <= start_s2_q;
        end
    end

    // Both pins see equal delay, so start setup to the clock is kept
    assign sclk_edge = sclk_s2_q && !sclk_s3_q;
    assign start_rise = start_s2_q && !start_s3_q;

    // ************************************************************
    // Sequencer state
    // ************************************************************
    lpar_state_e state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [PIX_COUNT-1:0] token_q;
    logic capture;
    logic last_edge;

    // Start is taken only from idle; a busy start is refused
    assign capture = sclk_edge && start_s2_q && (state_q == LPAR_IDLE);
    // The token leaving the last stage marks the 129th edge
    assign last_edge = sclk_edge && (state_q == LPAR_READ)
        && token_q[PIX_COUNT-1];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= LPAR_IDLE;
        end else begin
            case (state_q)
                LPAR_IDLE: begin
                    if (capture) begin
                        state_q <= LPAR_READ;
                    end
                end
                LPAR_READ: begin
                    if (last_edge) begin
                        state_q <= LPAR_IDLE;
                    end
                end
                default: begin
                    state_q <= LPAR_IDLE;
                end
            endcase
        end
    end

    // Sensor clock edges since capture; the capture edge is number one
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (capture) begin
            cnt_q <= FIRST_CLK;
        end else if (last_edge) begin
            cnt_q <= '0;
        end else if (sclk_edge && state_q == LPAR_READ) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // ************************************************************
    // Token shift register
    // ************************************************************
    // Each stage steps once per sensor clock; stage 0 takes the start
    generate
        for (genvar i = 0; i < PIX_COUNT; i++) begin : g_tok
            if (i == 0) begin : g_head
                always_ff @(posedge mclk or posedge rst) begin
                    if (rst) begin
                        token_q[i] <= 1'b0;
                    end else if (sclk_edge) begin
                        token_q[i] <= capture;
                    end
                end
            end else begin : g_body
                always_ff @(posedge mclk or posedge rst) begin
                    if (rst) begin
                        token_q[i] <= 1'b0;
                    end else if (sclk_edge) begin
                        token_q[i] <= token_q[i-1];
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Hold strobe and integrator reset
    // ************************************************************
    logic release_edge;

    // The 19th edge ends the reset window and restarts integration
    assign release_edge = sclk_edge && (state_q == LPAR_READ)
        && (cnt_q == RESET_CLKS);

    // Hold rises straight from the start edge, not from the clock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_strobe <= 1'b0;
        end else if (start_rise && state_q == LPAR_IDLE) begin
            hold_strobe <= 1'b1;
        end else if (release_edge) begin
            hold_strobe <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            integ_reset <= 1'b0;
        end else if (capture) begin
            integ_reset <= 1'b1;
        end else if (release_edge) begin
            integ_reset <= 1'b0;
        end
    end

    // ************************************************************
    // Frozen sample store, filled through the buffer
    // ************************************************************
    logic [PIX_BITS-1:0] pix_mem [PIX_COUNT];
    logic [CNT_W-1:0] wr_ptr_q;
    logic buf_valid;
    logic buf_take;
    logic [PIX_BITS-1:0] buf_data;

    // Samples only drain while capacitors are frozen; the buffer
    // absorbs early words and stalls the front end when full
    assign buf_take = hold_strobe && (wr_ptr_q != LAST_PIX_CLK);

    lpar_fifo #(
        .WIDTH(PIX_BITS),
        .DEPTH(BUF_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_data),
        .out_valid(buf_valid),
        .out_ready(buf_take),
        .out_data(buf_data)
    );

    // A new hold restarts filling from pixel 0
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
        end else if (start_rise && state_q == LPAR_IDLE) begin
            wr_ptr_q <= '0;
        end else if (buf_take && buf_valid) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (buf_take && buf_valid) begin
            pix_mem[wr_ptr_q[IDX_W-1:0]] <= buf_data;
        end
    end

    // ************************************************************
    // Pixel output stage
    // ************************************************************
    // Pixel k shows from edge k+1; a word not yet stored reads stale
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pixel_analog_out <= '0;
            pixel_index <= '0;
            pixel_out_oe_n <= 1'b1;
        end else if (capture) begin
            pixel_analog_out <= pix_mem[0];
            pixel_index <= '0;
            pixel_out_oe_n <= 1'b0;
        end else if (last_edge) begin
            pixel_analog_out <= '0;
            pixel_index <= '0;
            pixel_out_oe_n <= 1'b1;
        end else if (sclk_edge && state_q == LPAR_READ) begin
            pixel_analog_out <= pix_mem[cnt_q[IDX_W-1:0]];
            pixel_index <= cnt_q[IDX_W-1:0];
            pixel_out_oe_n <= 1'b0;
        end else if (state_q == LPAR_IDLE) begin
            pixel_out_oe_n <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            readout_busy <= 1'b0;
        end else if (capture) begin
            readout_busy <= 1'b1;
        end else if (last_edge) begin
            readout_busy <= 1'b0;
        end
    end

    // ************************************************************
    // Controller timing watch
    // ************************************************************
    logic [WAIT_W-1:0] wait_q;

    // Counts the charge transfer wait after the terminating edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_q <= '0;
            start_ok <= 1'b1;
        end else if (last_edge) begin
            wait_q <= WAIT_W'(CTW_CYC);
            start_ok <= 1'b0;
        end else if (capture) begin
            start_ok <= 1'b0;
        end else if (wait_q > WAIT_W'(1)) begin
            wait_q <= wait_q - 1'b1;
        end else if (state_q == LPAR_IDLE) begin
            wait_q <= '0;
            start_ok <= 1'b1;
        end
    end

    // Flags a start seen busy or held past one clock; it is ignored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            start_err <= 1'b0;
        end else begin
            start_err <= sclk_edge && start_s2_q
                && (state_q == LPAR_READ);
        end
    end

endmodule : lpar_readout

// >>> lpar_pkg.sv
// Shared constants of the linear pixel array readout sequencer.
// Assumes a single 20 MHz system clock; the sensor clock is a sampled pin.
package lpar_pkg;

    // ************************************************************
    // Array geometry and sequencing counts
    // ************************************************************
    localparam int PIX_COUNT = 128;
    localparam int PIX_W = 8;
    localparam int IDX_W = 7;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] RESET_CLKS = 8'h12;
    localparam logic [CNT_W-1:0] LAST_PIX_CLK = 8'h80;
    localparam logic [CNT_W-1:0] FIRST_CLK = 8'h01;
    localparam int FIFO_DEPTH = 16;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int MCLK_HZ = 20_000_000;
    localparam int CTW_US = 20;
    // Least time, rounded up to whole mclk cycles
    localparam int CTW_CYC = (CTW_US * (MCLK_HZ / 1000) + 999) / 1000;
    localparam int WAIT_W = 12;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [1:0] {
        LPAR_IDLE = 2'b01,
        LPAR_READ = 2'b10
    } lpar_state_e;

endpackage : lpar_pkg

// >>> lpar_fifo.sv
// Small first-word-fall-through FIFO with registered full and empty.
// Assumes both sides on one clock; data is held stable while not taken.
`timescale 1ns/1ps
module lpar_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_V = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic room_q;
    logic empty_q;
    logic push;
    logic pop;

    // ************************************************************
    // Handshake
    // ************************************************************
    assign push = in_valid && room_q;
    assign pop = !empty_q && out_ready;
    assign in_ready = room_q;
    assign out_valid = !empty_q;
    assign out_data = store[rd_q];

    // Occupancy; flags registered so ready is a clean flop
    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            room_q <= 1'b1;
            empty_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            room_q <= (cnt_d != DEPTH_V);
            empty_q <= (cnt_d == '0);
        end
    end

    // Pointers wrap naturally; depth is a power of two
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    // Storage needs no reset
    always_ff @(posedge mclk) begin
        if (push) begin
            store[wr_q] <= in_data;
        end
    end

endmodule : lpar_fifo

// >>> lpar_readout_chk.sv
// Port checks of the readout sequencer, bound into every instance.
// Assumes one mclk domain and rst asynchronous, active high.
`timescale 1ns/1ps
module lpar_readout_chk
    import lpar_pkg::*;
#(
    parameter int PIX_BITS = PIX_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sensor_clk,
    input wire logic scan_start,
    input wire logic sample_valid,
    input wire logic sample_ready,
    input wire logic [PIX_BITS-1:0] sample_data,
    input wire logic hold_strobe,
    input wire logic integ_reset,
    input wire logic [PIX_BITS-1:0] pixel_analog_out,
    input wire logic pixel_out_oe_n,
    input wire logic [IDX_W-1:0] pixel_index,
    input wire logic readout_busy,
    input wire logic start_ok,
    input wire logic start_err
);
    // ************************************************************
    // Sequencing relations
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    float_idle_a: assert property (!readout_busy |-> pixel_out_oe_n)
        else $error("output driven while idle");
    float_zero_a: assert property (pixel_out_oe_n |-> pixel_analog_out == 0)
        else $error("floating output not zero");
    reset_in_read_a: assert property (integ_reset |-> readout_busy)
        else $error("integrator reset outside readout");
    capture_state_a: assert property (
        $rose(readout_busy) |-> integ_reset && hold_strobe && pixel_index == 0)
        else $error("capture did not start hold and reset");
    index_step_a: assert property (
        $past(readout_busy) && readout_busy && $changed(pixel_index)
        |-> pixel_index == $past(pixel_index) + 7'h01)
        else $error("pixel index skipped");
    reset_end_a: assert property ($fell(integ_reset) |-> pixel_index == 7'h12)
        else $error("integrator reset not ended at edge 19");
    hold_end_a: assert property ($fell(hold_strobe) |-> pixel_index == 7'h12)
        else $error("hold not ended at edge 19");
    last_pixel_a: assert property (
        $fell(readout_busy) |-> $past(pixel_index) == 7'h7f && !start_ok)
        else $error("readout ended at wrong pixel");
    err_pulse_a: assert property (start_err |=> !start_err)
        else $error("start error longer than one cycle");
endmodule : lpar_readout_chk

bind lpar_readout lpar_readout_chk #(.PIX_BITS(PIX_BITS)) i_chk (
    .mclk(mclk), .rst(rst), .sensor_clk(sensor_clk), .scan_start(scan_start),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_data(sample_data), .hold_strobe(hold_strobe),
    .integ_reset(integ_reset), .pixel_analog_out(pixel_analog_out),
    .pixel_out_oe_n(pixel_out_oe_n), .pixel_index(pixel_index),
    .readout_busy(readout_busy), .start_ok(start_ok), .start_err(start_err));

// >>> lpar_ctrl_model.sv
// Behavioural external controller: start pulse and 129 sensor clocks.
// Assumes the bench waits for the charge wait before the next go.
`timescale 1ns/1ps
module lpar_ctrl_model (
    input wire logic mclk,
    input wire logic go,
    input wire logic [7:0] bad_edge,
    output logic sensor_clk,
    output logic scan_start,
    output logic done
);
    // ************************************************************
    // Frame generator
    // ************************************************************
    localparam int HALF = 4;
    int n;

    initial begin
        sensor_clk = 1'b0;
        scan_start = 1'b0;
        done = 1'b1;
    end

    // Clock stands low between frames; halves of 4 mclk suit the sync
    always begin
        @(posedge mclk iff go === 1'b1);
        #1 done = 1'b0;
        scan_start = 1'b1;
        for (n = 1; n <= 129; n++) begin
            repeat (HALF) @(posedge mclk);
            #1 sensor_clk = 1'b1;
            if (n == bad_edge) scan_start = 1'b1; // only on command
            repeat (HALF) @(posedge mclk);
            #1 sensor_clk = 1'b0;
            scan_start = 1'b0;
        end
        done = 1'b1;
    end
endmodule : lpar_ctrl_model

// >>> test_lpar_readout.sv
// Self-checking bench of the readout sequencer with a controller model.
// Assumes mclk at 20 MHz and a 16-word sample buffer.
`timescale 1ns/1ps
module test_lpar_readout;
    import lpar_pkg::*;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic mclk, rst, go, sample_valid, sample_ready, hold_strobe, integ_reset;
    logic pixel_out_oe_n, readout_busy, start_ok, start_err;
    logic sensor_clk, scan_start, done;
    logic [7:0] sample_data, pixel_analog_out, bad_edge, base;
    logic [IDX_W-1:0] pixel_index;
    int bad_count = 0;
    int n_tests = 0;
    int feed_i = 0;
    int err_cnt = 0;

    lpar_readout i_dut (.mclk(mclk), .rst(rst), .sensor_clk(sensor_clk),
        .scan_start(scan_start), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_data(sample_data),
        .hold_strobe(hold_strobe), .integ_reset(integ_reset),
        .pixel_analog_out(pixel_analog_out), .pixel_out_oe_n(pixel_out_oe_n),
        .pixel_index(pixel_index), .readout_busy(readout_busy),
        .start_ok(start_ok), .start_err(start_err));
    lpar_ctrl_model i_ctrl (.mclk(mclk), .go(go), .bad_edge(bad_edge),
        .sensor_clk(sensor_clk), .scan_start(scan_start), .done(done));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Counts refused starts for the frame scenarios
    always @(posedge mclk) begin
        if (start_err === 1'b1) err_cnt++;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    task automatic tick(input int cycles);
        repeat (cycles) @(posedge mclk);
        #1;
    endtask : tick

    task automatic wait_pin(input logic lvl);
        int g;
        g = 0;
        while (sensor_clk !== lvl && g < 50) begin
            tick(1);
            g++;
        end
        if (g >= 50) begin
            bad_count++;
            test_done();
        end
    endtask : wait_pin

    // Offers words in order until limit taken; stalls while ready is low
    task automatic feed(input int limit);
        int g;
        g = 0;
        sample_valid = (feed_i < limit);
        sample_data = base + feed_i[7:0];
        while (sample_valid === 1'b1 && g < 3000) begin
            @(posedge mclk);
            if (sample_ready === 1'b1) feed_i++;
            #1;
            sample_valid = (feed_i < limit);
            sample_data = base + feed_i[7:0];
            g++;
        end
        if (sample_valid === 1'b1) begin
            bad_count++;
            test_done();
        end
    endtask : feed

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic check_idle;
        check("oe_n", pixel_out_oe_n, 1'b1);
        check("out", pixel_analog_out, 8'h00);
        check("busy", readout_busy, 1'b0);
        check("start_ok", start_ok, 1'b1);
        check("ready", sample_ready, 1'b1);
        check("hold", hold_strobe, 1'b0);
    endtask : check_idle

    task automatic fill_buffer;
        feed(16);
        tick(1);
        sample_valid = 1'b1;
        tick(3);
        check("ready full", sample_ready, 1'b0);
        check("words taken", feed_i[15:0], 16'h0010);
    endtask : fill_buffer

    task automatic run_frame(input logic [7:0] bad);
        int n, c, e0, lo;
        e0 = err_cnt;
        lo = 0;
        bad_edge = bad;
        go = 1'b1;
        fork
            feed(128);
            begin
                tick(1);
                go = 1'b0;
                for (n = 1; n <= 129; n++) begin
                    wait_pin(1'b1);
                    if (n == 1) begin
                        check("early hold", hold_strobe, 1'b1);
                        check("early busy", readout_busy, 1'b0);
                    end
                    tick(5);
                    if (n <= 128) begin
                        check("oe_n", pixel_out_oe_n, 1'b0);
                        check("pixel", pixel_analog_out, 8'(base + n - 1));
                        check("index", pixel_index, n - 1);
                        check("integ", integ_reset, n <= 18);
                        check("hold", hold_strobe, n <= 18);
                        if (integ_reset === 1'b0) lo++;
                        wait_pin(1'b0);
                    end else begin
                        check("end oe_n", pixel_out_oe_n, 1'b1);
                        check("end out", pixel_analog_out, 8'h00);
                        check("end busy", readout_busy, 1'b0);
                        check("end ok", start_ok, 1'b0);
                        c = 0;
                        while (start_ok !== 1'b1 && c < 600) begin
                            tick(1);
                            c++;
                        end
                        check("wait", c >= 390 && c <= 400, 1'b1);
                    end
                end
            end
        join
        check("refused start", err_cnt != e0, bad != 0);
        check("free edges", lo[15:0], 16'h006e);
        check("ctrl done", done, 1'b1);
    endtask : run_frame

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rst = 1'b1;
        go = 1'b0;
        sample_valid = 1'b0;
        sample_data = 8'h00;
        bad_edge = 8'h00;
        base = 8'h30;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        tick(1);
        check_idle();
        fill_buffer();
        run_frame(8'h00);
        feed_i = 0;
        base = 8'hc0;
        run_frame(8'h32); // start_ok seen before this go
        check_idle();
        test_done();
    end
endmodule : test_lpar_readout
